// >>> common/fault_status_params.svh
// constants for the configurable fault status capture block
// assumes a word-wide register port with byte enables on writes
// Behaviour
// RL1 - divide by zero sets bit 25 when trapping
// RL2 - divide trap only when config bit set
// RL3 - unaligned access sets bit 24 when trapping
// RL4 - multiple or doubleword unaligned always faults
// RL5 - coprocessor access sets bit 19
// RL6 - bad return code load sets bit 18
// RL7 - bad status use sets 17, not undefined
// RL8 - undecodable instruction sets bit 16
// RL9 - precise faults stack the faulting PC
// RL10 - known bus fault address sets bit 15
// RL11 - hard fault handler clears address valid; the code has no handler input, bit 15 clears on a later memmanage fault or a written one
// RL12 - entry stacking bus fault sets bit 12
// RL13 - return unstacking bus fault sets bit 11
// RL14 - imprecise bus error sets bit 10, pends
// RL15 - precise bus error sets 9, captures address
// RL16 - issued fetch bus error sets bit 8
// RL17 - valid memmanage address sets bit 7
// RL18 - entry stacking violation sets bit 4
// RL19 - return unstacking violation sets bit 3
// RL20 - writing one clears a flag
// RL21 - reserved bits read zero
// RL22 - usage, bus, memmanage bytes byte accessible
// RL23 - register resets to zero
// RL24 - flags sticky, many at once, zero ignored
`ifndef FAULT_STATUS_PARAMS_SVH
`define FAULT_STATUS_PARAMS_SVH
`define FCS_ADDR_STATUS   8'h28
`define FCS_ADDR_CONFIG   8'h14
`define FCS_ADDR_BUSADDR  8'h38
`define FCS_ADDR_MEMMANAGE_FAULT_ADDRESS_REG   8'h34
`define FCS_RESET         32'h0000_0000
`define FCS_IMPL_MASK     32'h030f_9f98
`define FCS_BIT_ZERO_DIVISOR_FLAG      25
`define FCS_BIT_UNAL      24
`define FCS_BIT_COPROCESSOR_ACCESS_FLAG      19
`define FCS_BIT_BADPC     18
`define FCS_BIT_BADST     17
`define FCS_BIT_UNKNOWN_OPCODE_FLAG     16
`define FCS_BIT_BAV       15
`define FCS_BIT_BSTK      12
`define FCS_BIT_BUSTK     11
`define FCS_BIT_ASYNC_BUS_ERROR_FLAG     10
`define FCS_BIT_PRECISE   9
`define FCS_BIT_FETCH_BUS_ERROR_FLAG      8
`define FCS_BIT_MAV       7
`define FCS_BIT_MSTK      4
`define FCS_BIT_MUSTK     3
`define CFG_BIT_UNAL_TRP  3
`define CFG_BIT_ZERO_DIVISOR_FLAG_TRP  4
`define CFG_MASK          32'h0000_0018
`endif

// >>> common/fault_status_pkg.sv
// types for the configurable fault status capture block
// assumes fault_status_params.svh supplies the numbers
package fault_status_pkg;
    typedef logic [31:0] word_t;   // one register word
    typedef logic [3:0]  lanes_t;  // byte enables
endpackage

// >>> rtl/fault_event_decode.sv
// fault event decoder: turns pipeline and bus reports into set bits
// assumes one-cycle event pulses from the core, synchronous to clk_i
`timescale 1ns/1ps
`include "fault_status_params.svh"
module fault_event_decode (
    input  wire logic        div_zero_i,      // divide with zero divisor
    input  wire logic        unaligned_i,     // unaligned single access
    input  wire logic        unaligned_multi_i, // unaligned ldm/stm/ldrd/strd
    input  wire logic        coproc_i,        // coprocessor access attempt
    input  wire logic        bad_pc_load_i,   // illegal return code load
    input  wire logic        bad_state_i,     // illegal status register use
    input  wire logic        unknown_opcode_flag_i,         // undecodable instruction
    input  wire logic        bus_stack_i,     // entry stacking bus fault
    input  wire logic        bus_unstack_i,   // return unstacking bus fault
    input  wire logic        bus_async_i,     // imprecise data bus error
    input  wire logic        bus_precise_i,   // precise data bus error
    input  wire logic        fetch_err_issue_i, // faulting fetch issued
    input  wire logic        mm_fault_addr_i, // memmanage fault with address
    input  wire logic        mm_stack_i,      // entry stacking violation
    input  wire logic        mm_unstack_i,    // return unstacking violation
    input  wire logic        div_trap_en_i,   // divide trap enable
    input  wire logic        unal_trap_en_i,  // unaligned trap enable
    output fault_status_pkg::word_t set_o,    // bits to set this cycle
    output logic             bav_clr_o        // later memmanage fault drops bus valid
);
    // combinational map from events to flag positions
    always_comb
    begin
        set_o = '0;
        set_o[`FCS_BIT_ZERO_DIVISOR_FLAG]    = div_zero_i & div_trap_en_i; // RL1 RL2
        set_o[`FCS_BIT_UNAL]    = (unaligned_i & unal_trap_en_i) | unaligned_multi_i; // RL3 RL4
        set_o[`FCS_BIT_COPROCESSOR_ACCESS_FLAG]    = coproc_i; // RL5
        set_o[`FCS_BIT_BADPC]   = bad_pc_load_i; // RL6
        set_o[`FCS_BIT_BADST]   = bad_state_i & ~unknown_opcode_flag_i; // RL7
        set_o[`FCS_BIT_UNKNOWN_OPCODE_FLAG]   = unknown_opcode_flag_i; // RL8
        set_o[`FCS_BIT_BSTK]    = bus_stack_i; // RL12
        set_o[`FCS_BIT_BUSTK]   = bus_unstack_i; // RL13
        set_o[`FCS_BIT_ASYNC_BUS_ERROR_FLAG]   = bus_async_i; // RL14
        set_o[`FCS_BIT_PRECISE] = bus_precise_i; // RL15
        set_o[`FCS_BIT_BAV]     = bus_precise_i; // RL10
        set_o[`FCS_BIT_FETCH_BUS_ERROR_FLAG]    = fetch_err_issue_i; // RL16
        set_o[`FCS_BIT_MAV]     = mm_fault_addr_i; // RL17
        set_o[`FCS_BIT_MSTK]    = mm_stack_i; // RL18
        set_o[`FCS_BIT_MUSTK]   = mm_unstack_i; // RL19
        // a later memmanage fault overwrites context, so bus valid drops
        bav_clr_o = mm_fault_addr_i & ~bus_precise_i; // RL10
    end
endmodule

// >>> rtl/fault_addr_capture.sv
// fault address holder for bus and memmanage faults
// assumes the core presents the faulting address with the event
`timescale 1ns/1ps
`include "fault_status_params.svh"
module fault_addr_capture (
    input  wire logic                    clk_i,     // system clock
    input  wire logic                    reset_i,   // sync reset, high
    input  wire logic                    load_i,    // capture strobe
    input  fault_status_pkg::word_t      addr_i,    // faulting address
    output fault_status_pkg::word_t      addr_o     // held address
);
    typedef struct packed {
        fault_status_pkg::word_t addr;  // captured address
    } cap_s;
    cap_s st_ff;
    cap_s nxt_st;
    // load only on an address-carrying fault
    always_comb
    begin
        nxt_st = st_ff;
        if (load_i)
        begin
            nxt_st.addr = addr_i; // RL15
        end
    end
    // register the state copy
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end
    assign addr_o = st_ff.addr;
endmodule

// >>> rtl/fault_status_capture.sv
// sticky fault cause status with write-one-to-clear and trap config
// assumes a single-cycle register master; reads answer next cycle
`timescale 1ns/1ps
`include "fault_status_params.svh"
module fault_status_capture (
    input  wire logic                 clk_i,             // system clock
    input  wire logic                 reset_i,           // sync reset, high
    input  wire logic [7:0]           reg_addr_i,        // byte address
    input  fault_status_pkg::word_t   reg_wdata_i,       // write data
    input  fault_status_pkg::lanes_t  reg_be_i,          // byte enables
    input  wire logic                 reg_wr_i,          // write strobe
    input  wire logic                 reg_rd_i,          // read strobe
    output fault_status_pkg::word_t   reg_rdata_o,       // read data
    input  wire logic                 div_zero_i,        // divide by zero
    input  wire logic                 unaligned_i,       // unaligned access
    input  wire logic                 unaligned_multi_i, // unaligned multiple
    input  wire logic                 coproc_i,          // coprocessor use
    input  wire logic                 bad_pc_load_i,     // bad return load
    input  wire logic                 bad_state_i,       // bad status use
    input  wire logic                 unknown_opcode_flag_i,           // undefined opcode
    input  wire logic                 bus_stack_i,       // stacking bus fault
    input  wire logic                 bus_unstack_i,     // unstacking bus fault
    input  wire logic                 bus_async_i,       // imprecise error
    input  wire logic                 bus_precise_i,     // precise error
    input  fault_status_pkg::word_t   bus_addr_i,        // precise address
    input  wire logic                 fetch_err_issue_i, // fetch error issued
    input  wire logic                 mm_fault_addr_i,   // memmanage with addr
    input  fault_status_pkg::word_t   mm_addr_i,         // memmanage address
    input  wire logic                 mm_stack_i,        // stacking violation
    input  wire logic                 mm_unstack_i,      // unstacking violation
    input  wire logic                 bus_prio_blocked_i, // higher prio running
    output logic                      stack_fault_pc_o,  // stack faulting pc
    output logic                      bus_fault_pend_o,  // imprecise pending
    output logic                      div_trap_en_o,     // divide trap on
    output logic                      unal_trap_en_o     // unaligned trap on
);
    typedef struct packed {
        fault_status_pkg::word_t status;   // sticky flags
        fault_status_pkg::word_t cfg;      // trap enables
        fault_status_pkg::word_t rdata;    // registered read data
        logic                    pend;     // imprecise fault held back
        logic                    pc_flag;  // precise fault seen last cycle
    } st_s;
    st_s st_ff;
    st_s nxt_st;
    fault_status_pkg::word_t set_w;     // decoded set bits
    logic                    bav_clr_w; // bus valid drop
    fault_status_pkg::word_t bus_addr_w;
    fault_status_pkg::word_t mm_addr_w;

    // expand byte enables to a bit mask, used for both registers
    function automatic fault_status_pkg::word_t lane_mask(
        input fault_status_pkg::lanes_t be);
        fault_status_pkg::word_t m;
        m = '0;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

    fault_event_decode u_decode (
        .div_zero_i        (div_zero_i),
        .unaligned_i       (unaligned_i),
        .unaligned_multi_i (unaligned_multi_i),
        .coproc_i          (coproc_i),
        .bad_pc_load_i     (bad_pc_load_i),
        .bad_state_i       (bad_state_i),
        .unknown_opcode_flag_i           (unknown_opcode_flag_i),
        .bus_stack_i       (bus_stack_i),
        .bus_unstack_i     (bus_unstack_i),
        .bus_async_i       (bus_async_i),
        .bus_precise_i     (bus_precise_i),
        .fetch_err_issue_i (fetch_err_issue_i),
        .mm_fault_addr_i   (mm_fault_addr_i),
        .mm_stack_i        (mm_stack_i),
        .mm_unstack_i      (mm_unstack_i),
        .div_trap_en_i     (st_ff.cfg[`CFG_BIT_ZERO_DIVISOR_FLAG_TRP]),
        .unal_trap_en_i    (st_ff.cfg[`CFG_BIT_UNAL_TRP]),
        .set_o             (set_w),
        .bav_clr_o         (bav_clr_w)
    );

    // stacking faults never write an address
    fault_addr_capture u_bus_addr (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .load_i  (bus_precise_i), // RL15
        .addr_i  (bus_addr_i),
        .addr_o  (bus_addr_w)
    );

    fault_addr_capture u_mm_addr (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .load_i  (mm_fault_addr_i), // RL17
        .addr_i  (mm_addr_i),
        .addr_o  (mm_addr_w)
    );

    // next-state logic: clears first, then sets so an event wins
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rdata = '0;
        // write ones clear, zeros and reserved lanes do nothing
        if (reg_wr_i && reg_addr_i == `FCS_ADDR_STATUS)
        begin
            nxt_st.status = st_ff.status
                & ~(reg_wdata_i & lane_mask(reg_be_i)); // RL20 RL22 RL24
        end
        if (reg_wr_i && reg_addr_i == `FCS_ADDR_CONFIG)
        begin
            nxt_st.cfg = (st_ff.cfg & ~lane_mask(reg_be_i))
                | (reg_wdata_i & lane_mask(reg_be_i) & `CFG_MASK); // RL2
        end
        // a later memmanage fault invalidates the bus address
        if (bav_clr_w)
        begin
            nxt_st.status[`FCS_BIT_BAV] = 1'b0; // RL10
        end
        // hardware sets override any clear in the same cycle
        nxt_st.status = (nxt_st.status | set_w) & `FCS_IMPL_MASK; // RL24 RL21
        // imprecise fault waits while higher priority code runs
        if (bus_async_i && bus_prio_blocked_i)
            nxt_st.pend = 1'b1; // RL14
        else if (!bus_prio_blocked_i)
            nxt_st.pend = 1'b0; // RL14
        // precise faults report the faulting instruction for stacking
        nxt_st.pc_flag = div_zero_i & st_ff.cfg[`CFG_BIT_ZERO_DIVISOR_FLAG_TRP]
            | unknown_opcode_flag_i | (bad_state_i & ~unknown_opcode_flag_i) | bad_pc_load_i
            | bus_precise_i; // RL9 RL6
        // read data mux, unmapped addresses read zero
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `FCS_ADDR_STATUS:  nxt_st.rdata = st_ff.status; // RL21
                `FCS_ADDR_CONFIG:  nxt_st.rdata = st_ff.cfg;
                `FCS_ADDR_BUSADDR: nxt_st.rdata = bus_addr_w;
                `FCS_ADDR_MEMMANAGE_FAULT_ADDRESS_REG:  nxt_st.rdata = mm_addr_w;
                default:           nxt_st.rdata = '0;
            endcase
        end
    end

    // register the state copy
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            st_ff.status  <= `FCS_RESET; // RL23
            st_ff.cfg     <= '0;
            st_ff.rdata   <= '0;
            st_ff.pend    <= 1'b0;
            st_ff.pc_flag <= 1'b0;
        end
        else
            st_ff <= nxt_st;
    end

    assign reg_rdata_o      = st_ff.rdata;
    assign stack_fault_pc_o = st_ff.pc_flag;
    assign bus_fault_pend_o = st_ff.pend;
    assign div_trap_en_o    = st_ff.cfg[`CFG_BIT_ZERO_DIVISOR_FLAG_TRP];
    assign unal_trap_en_o   = st_ff.cfg[`CFG_BIT_UNAL_TRP];
endmodule

// >>> verif/fault_status_capture_props.sv
// checker for the fault status block, bound to its top module
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`include "fault_status_params.svh"
module fault_status_capture_props (
    input wire logic                clk_i,
    input wire logic                reset_i,
    input wire logic [7:0]          reg_addr_i,
    input fault_status_pkg::word_t  reg_wdata_i,
    input fault_status_pkg::lanes_t reg_be_i,
    input wire logic                reg_wr_i,
    input wire logic                reg_rd_i,
    input fault_status_pkg::word_t  reg_rdata_o,
    input wire logic                div_zero_i,
    input wire logic                unaligned_multi_i,
    input wire logic                bad_pc_load_i,
    input wire logic                bad_state_i,
    input wire logic                unknown_opcode_flag_i,
    input wire logic                bus_async_i,
    input wire logic                bus_precise_i,
    input wire logic                bus_prio_blocked_i,
    input wire logic                stack_fault_pc_o,
    input wire logic                bus_fault_pend_o,
    input wire logic                div_trap_en_o,
    input wire logic                unal_trap_en_o
);
    fault_status_pkg::word_t wd_ff; // write data one cycle back
    // keeps the written config value for the cycle it shows up
    always_ff @(posedge clk_i)
    begin
        wd_ff <= reg_wdata_i;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence s_cfg_wr;
        reg_wr_i && reg_addr_i == `FCS_ADDR_CONFIG && reg_be_i[0];
    endsequence
    sequence s_rd_stat;
        reg_rd_i && reg_addr_i == `FCS_ADDR_STATUS;
    endsequence
    property p_cfg_div; s_cfg_wr |=> div_trap_en_o == wd_ff[4]; endproperty
    a_cfg_div: assert property (p_cfg_div) else $error("divide trap enable wrong");
    property p_cfg_unal; s_cfg_wr |=> unal_trap_en_o == wd_ff[3]; endproperty
    a_cfg_unal: assert property (p_cfg_unal) else $error("unaligned trap enable wrong");
    property p_div; div_zero_i && div_trap_en_o ##1 s_rd_stat |=> reg_rdata_o[25]; endproperty
    a_div: assert property (p_div) else $error("divide flag not seen");
    property p_multi; unaligned_multi_i ##1 s_rd_stat |=> reg_rdata_o[24]; endproperty
    a_multi: assert property (p_multi) else $error("multiple access flag not seen");
    property p_unknown_opcode_flag; unknown_opcode_flag_i ##1 s_rd_stat |=> reg_rdata_o[16]; endproperty
    a_unknown_opcode_flag: assert property (p_unknown_opcode_flag) else $error("opcode flag not seen");
    property p_pc;
        (div_zero_i && div_trap_en_o) || unknown_opcode_flag_i || bad_state_i || bus_precise_i
            || bad_pc_load_i |=> stack_fault_pc_o;
    endproperty
    a_pc: assert property (p_pc) else $error("faulting pc not stacked");
    // the stacking hint is a one-cycle pulse, never left standing
    property p_pc_idle;
        !((div_zero_i && div_trap_en_o) || unknown_opcode_flag_i || bad_state_i || bus_precise_i
            || bad_pc_load_i) |=> !stack_fault_pc_o;
    endproperty
    a_pc_idle: assert property (p_pc_idle) else $error("stacked pc flag not a pulse");
    property p_pend; bus_async_i && bus_prio_blocked_i |=> bus_fault_pend_o; endproperty
    a_pend: assert property (p_pend) else $error("async fault not pending");
    property p_pend_drop; !bus_prio_blocked_i |=> !bus_fault_pend_o; endproperty
    a_pend_drop: assert property (p_pend_drop) else $error("pending fault not released");
    property p_resv; s_rd_stat |=> (reg_rdata_o & ~`FCS_IMPL_MASK) == 32'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved bits not zero");
endmodule
bind fault_status_capture fault_status_capture_props fault_status_capture_props_inst (
    .clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_be_i(reg_be_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .div_zero_i(div_zero_i), .unaligned_multi_i(unaligned_multi_i), .bad_state_i(bad_state_i),
    .bad_pc_load_i(bad_pc_load_i),
    .unknown_opcode_flag_i(unknown_opcode_flag_i), .bus_async_i(bus_async_i), .bus_precise_i(bus_precise_i),
    .bus_prio_blocked_i(bus_prio_blocked_i), .stack_fault_pc_o(stack_fault_pc_o),
    .bus_fault_pend_o(bus_fault_pend_o), .div_trap_en_o(div_trap_en_o),
    .unal_trap_en_o(unal_trap_en_o));

// >>> verif/fault_core_model.sv
// core-side model: turns a requested event vector into one-cycle pulses
// assumes the bench changes its request just after a rising edge
`timescale 1ns/1ps
module fault_core_model (
    input  wire logic              clk_i,      // system clock
    input  wire logic [14:0]       req_i,      // events wanted
    input  fault_status_pkg::word_t addr_i,    // address to present
    input  wire logic              blk_i,      // higher priority running
    output logic [14:0]            ev_o,       // one-cycle event pulses
    output fault_status_pkg::word_t bus_addr_o, // precise address
    output fault_status_pkg::word_t mm_addr_o,  // memmanage address
    output logic                   blk_o       // priority level
);
    // addresses are inverted outside their event so a late capture fails
    always_ff @(posedge clk_i)
    begin
        ev_o       <= req_i;
        blk_o      <= blk_i;
        bus_addr_o <= req_i[10] ? addr_i : ~addr_i;
        mm_addr_o  <= req_i[12] ? addr_i : ~addr_i;
    end
endmodule

// >>> verif/tb_fault_status_capture.sv
// bench for the fault status block: core model plus register master
// assumes reads answer one cycle later and events pulse one cycle
`timescale 1ns/1ps
`include "fault_status_params.svh"
module tb_fault_status_capture;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    fault_status_pkg::word_t reg_wdata_i = 32'h0;
    fault_status_pkg::lanes_t reg_be_i = 4'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic rd_ff = 1'b0;      // read strobe one cycle back
    logic blk = 1'b0;
    logic blk_o;
    logic [14:0] req = 15'h0;
    logic [14:0] ev;
    fault_status_pkg::word_t reg_rdata_o, bus_a, mm_a, e, exp_v;
    fault_status_pkg::word_t addr = 32'h0;
    fault_status_pkg::word_t rnd = 32'hca27777d;
    fault_status_pkg::word_t q[$]; // expected read data, oldest first
    int n_fail = 0;
    int comparisons = 0;
    int bitpos[15] = '{25, 24, 24, 19, 18, 17, 16, 12, 11, 10, 9, 8, 7, 4, 3};
    fault_core_model fault_core_model_inst (.clk_i(clk_i), .req_i(req), .addr_i(addr),
        .blk_i(blk), .ev_o(ev), .bus_addr_o(bus_a), .mm_addr_o(mm_a), .blk_o(blk_o));
    fault_status_capture fault_status_capture_inst (.clk_i(clk_i), .reset_i(reset_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_be_i(reg_be_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .div_zero_i(ev[0]), .unaligned_i(ev[1]), .unaligned_multi_i(ev[2]), .coproc_i(ev[3]),
        .bad_pc_load_i(ev[4]), .bad_state_i(ev[5]), .unknown_opcode_flag_i(ev[6]), .bus_stack_i(ev[7]),
        .bus_unstack_i(ev[8]), .bus_async_i(ev[9]), .bus_precise_i(ev[10]),
        .bus_addr_i(bus_a), .fetch_err_issue_i(ev[11]), .mm_fault_addr_i(ev[12]),
        .mm_addr_i(mm_a), .mm_stack_i(ev[13]), .mm_unstack_i(ev[14]),
        .bus_prio_blocked_i(blk_o), .stack_fault_pc_o(), .bus_fault_pend_o(),
        .div_trap_en_o(), .unal_trap_en_o());
    initial forever #5 clk_i = ~clk_i;
    function automatic fault_status_pkg::word_t xs(fault_status_pkg::word_t s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic wr(logic [7:0] a, fault_status_pkg::word_t d, fault_status_pkg::lanes_t b);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_be_i <= b;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, fault_status_pkg::word_t x);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        q.push_back(x);
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
    endtask
    // events pulse in the cycle right before the next read or write strobe
    task automatic fire(logic [14:0] v);
        @(posedge clk_i);
        req <= v;
        @(posedge clk_i);
        req <= 15'h0;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // read data stand only in the cycle after the strobe: sample mid-cycle
    always @(posedge clk_i) rd_ff <= reg_rd_i;
    always @(negedge clk_i)
    begin
        if (rd_ff)
        begin
            exp_v = q.pop_front();
            comparisons++;
            if (reg_rdata_o !== exp_v)
            begin
                n_fail++;
                $display("[FAIL] %0t exp %h got %h", $time, exp_v, reg_rdata_o);
            end
        end
    end
    initial
    begin
        repeat (3000) @(posedge clk_i);
        n_fail++;
        summarize();
    end
    initial
    begin
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(`FCS_ADDR_STATUS, `FCS_RESET);
        wr(`FCS_ADDR_CONFIG, `CFG_MASK, 4'hf);
        rd(`FCS_ADDR_CONFIG, `CFG_MASK);
        for (int i = 0; i < 15; i++)
        begin
            rnd = xs(rnd);
            addr <= rnd;
            fire(15'h1 << i);
            e = (32'h1 << bitpos[i]) | ((i == 10) ? 32'h8000 : 32'h0);
            rd(`FCS_ADDR_STATUS, e);
            if (i == 10) rd(`FCS_ADDR_BUSADDR, rnd);
            if (i == 12) rd(`FCS_ADDR_MEMMANAGE_FAULT_ADDRESS_REG, rnd);
            wr(`FCS_ADDR_STATUS, 32'hffff_ffff, 4'hf);
            rd(`FCS_ADDR_STATUS, 32'h0);
        end
        $display("test 1 done");
        wr(`FCS_ADDR_CONFIG, 32'h0, 4'hf);
        fire(15'h0003);
        rd(`FCS_ADDR_STATUS, 32'h0);
        fire(15'h0004);
        rd(`FCS_ADDR_STATUS, 32'h0100_0000);
        fire(15'h0060);
        rd(`FCS_ADDR_STATUS, 32'h0101_0000);
        fire(15'h7fbf);
        wr(`FCS_ADDR_STATUS, 32'h0, 4'hf);
        rd(`FCS_ADDR_STATUS, 32'h010f_9f98);
        wr(`FCS_ADDR_STATUS, 32'hffff_ffff, 4'h2);
        rd(`FCS_ADDR_STATUS, 32'h010f_0098);
        wr(`FCS_ADDR_STATUS, 32'hffff_ffff, 4'hc);
        rd(`FCS_ADDR_STATUS, 32'h0000_0098);
        wr(`FCS_ADDR_STATUS, 32'hffff_ffff, 4'h1);
        rd(`FCS_ADDR_STATUS, 32'h0);
        $display("test 2 done");
        fire(15'h0400);
        fire(15'h1000);
        rd(`FCS_ADDR_STATUS, 32'h0000_0280);
        fire(15'h0400);
        wr(`FCS_ADDR_STATUS, 32'h0000_8000, 4'hf);
        rd(`FCS_ADDR_STATUS, 32'h0000_0280);
        blk <= 1'b1;
        fire(15'h0200);
        blk <= 1'b0;
        rd(`FCS_ADDR_STATUS, 32'h0000_0680);
        rd(8'h00, 32'h0);
        $display("test 3 done");
        summarize();
    end
endmodule
